// ==== src/adc_seq_pkg.sv ====
// Constants, register map and carriers for the conversion sequencer.
// Assumes a Wishbone classic slave bus with 8-bit data in the low byte lanes.
// Contract
// - Each conversion takes exactly twelve bit periods from its start.
// - Clock select 000/100/001/101/010/110 gives 2/4/8/16/32/64 clocks; 011 means RC.
// - RC source gives a bit period of about 4 us, oscillator independent.
// - Port reads return zero on analog pins; digital inputs stay convertible.
// - Channel select and pin directions never gate a conversion.
// - Clearing the go flag mid conversion aborts it at once.
// - An abort leaves the result pair untouched.
// - After an abort wait two bit periods, then acquire the selected channel.
// - Compare unit two in mode 1011 with converter on sets go and starts.
// - Each special event trigger clears the associated timer counter.
// - Converter off ignores the trigger, but the timer is still cleared.
// - Completion loads result, clears go and sets the done flag.
// - Justify set right-aligns result; clear left-aligns it, padding with zeros.
// - Reset returns all registers, switching off and aborting conversions.
// - Top clock select bit is bit 6 of control two; low bits in control one.
package adc_seq_pkg;
   localparam logic [2:0] CTRL1_ADDR = 3'h0;
   localparam logic [2:0] CTRL2_ADDR = 3'h1;
   localparam logic [2:0] RESH_ADDR = 3'h2;
   localparam logic [2:0] RESL_ADDR = 3'h3;
   localparam logic [2:0] PORT_ADDR = 3'h4;
   localparam logic [2:0] ANCFG_ADDR = 3'h5;
   localparam logic [2:0] STAT_ADDR = 3'h6;
   localparam int CLK_MHZ = 50;
   localparam int TRIG_MODE_W = 4;
   localparam logic [3:0] TRIG_MODE_SPECIAL = 4'hb;
   localparam logic [3:0] CONV_PERIODS = 4'hc;
   localparam logic [3:0] ABORT_PERIODS = 4'h2;
   localparam logic [3:0] SAMPLE_PERIODS = 4'h1;
   localparam logic [3:0] RES_BITS = 4'ha;
   localparam logic [2:0] SEL_RC = 3'h3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_WAIT = 2'b11
   } seq_state_e;

   typedef struct packed {
      logic [1:0] clkSelLow;
      logic [2:0] channelSelect;
      logic goFlag;
      logic converterOn;
   } ctrl_one_s;

   typedef struct packed {
      logic resultJustify;
      logic clkSelHigh;
   } ctrl_two_s;
endpackage

// ==== src/adc_conversion_sequencer.sv ====
// Sequencer for a 10-bit successive-approximation converter.
// Assumes a Wishbone classic master, a comparator input and an RC clock pin.
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer #(
   parameter int PINS = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [2:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   input wire logic wb_sel_i,
   output logic [7:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rcClk,
   input wire logic compGreater,
   input wire logic [PINS-1:0] pinLevel,
   input wire logic [3:0] compare2ModeField,
   input wire logic specialEventTrig,
   output logic [2:0] channelSelect,
   output logic sampleSwitch,
   output logic [9:0] dacCode,
   output logic timerClear,
   output logic conversionDoneFlag,
   output logic conversionBusy
);
   adc_seq_pkg::ctrl_one_s ctrl1_r;
   adc_seq_pkg::ctrl_two_s ctrl2_r;
   logic [PINS-1:0] analogCfg_r;
   logic [7:0] resH_r;
   logic [7:0] resL_r;
   logic [9:0] sar_r;
   logic [3:0] periods_r;
   logic [5:0] divCnt_r;
   logic [2:0] rcSync_r;
   logic rcSeen_r;
   logic tick;
   logic [2:0] clkSel;
   logic [5:0] divLast;
   logic busAccess;
   logic wrAccess;
   logic wrCtrl1;
   logic [3:0] bitIdx;
   logic trigStart;
   logic ack_r;
   adc_seq_pkg::seq_state_e state_r;

   assign clkSel = {ctrl2_r.clkSelHigh, ctrl1_r.clkSelLow};
   assign busAccess = wb_cyc_i && wb_stb_i && !ack_r;
   // Writes land at the edge where the master sees ack
   assign wrAccess = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i;
   assign wrCtrl1 = wrAccess && wb_adr_i == adc_seq_pkg::CTRL1_ADDR;
   assign bitIdx = adc_seq_pkg::SAMPLE_PERIODS + adc_seq_pkg::RES_BITS - 4'h1 - periods_r;
   assign trigStart = specialEventTrig && ctrl1_r.converterOn
      && compare2ModeField == adc_seq_pkg::TRIG_MODE_SPECIAL;
   assign timerClear = specialEventTrig;
   assign channelSelect = ctrl1_r.channelSelect;
   assign conversionBusy = state_r != adc_seq_pkg::ST_IDLE;
   assign wb_ack_o = ack_r;

   // Divide ratio: low pair picks 2/8/32-group (11 is RC), high bit doubles
   always_comb begin
      case (clkSel)
         3'h0: divLast = 6'h01;
         3'h4: divLast = 6'h03;
         3'h1: divLast = 6'h07;
         3'h5: divLast = 6'h0f;
         3'h2: divLast = 6'h1f;
         3'h6: divLast = 6'h3f;
         default: divLast = 6'h3f;
      endcase
   end

   // Oscillator divider
   always_ff @(posedge core_clk) begin
      if (rst || divCnt_r >= divLast || !conversionBusy) begin
         divCnt_r <= 6'h00;
      end else begin
         divCnt_r <= divCnt_r + 6'h01;
      end
   end

   // RC clock synchroniser and edge detect
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rcSync_r <= 3'h0;
         rcSeen_r <= 1'b0;
      end else begin
         rcSync_r <= {rcSync_r[1:0], rcClk};
         if (rcSync_r[1] == rcSync_r[2]) begin
            rcSeen_r <= rcSync_r[2];
         end
      end
   end

   always_comb begin
      if (clkSel[1:0] == adc_seq_pkg::SEL_RC[1:0]) begin
         tick = rcSync_r[1] == rcSync_r[2] && rcSync_r[2] && !rcSeen_r;
      end else begin
         tick = conversionBusy && divCnt_r >= divLast;
      end
   end

   // Sequencer state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= adc_seq_pkg::ST_IDLE;
         periods_r <= 4'h0;
         sar_r <= 10'h000;
      end else begin
         case (state_r)
            adc_seq_pkg::ST_IDLE: begin
               if (ctrl1_r.goFlag) begin
                  state_r <= adc_seq_pkg::ST_CONV;
                  periods_r <= 4'h0;
                  sar_r <= 10'h200;
               end
            end
            adc_seq_pkg::ST_CONV: begin
               if (!ctrl1_r.goFlag) begin
                  state_r <= adc_seq_pkg::ST_WAIT;
                  periods_r <= 4'h0;
               end else if (tick) begin
                  periods_r <= periods_r + 4'h1;
                  if (periods_r >= adc_seq_pkg::SAMPLE_PERIODS
                      && periods_r < adc_seq_pkg::SAMPLE_PERIODS + adc_seq_pkg::RES_BITS) begin
                     sar_r[bitIdx] <= compGreater;
                     if (bitIdx != 4'h0) begin
                        sar_r[bitIdx - 4'h1] <= 1'b1;
                     end
                  end
                  if (periods_r == adc_seq_pkg::CONV_PERIODS - 4'h1) begin
                     state_r <= adc_seq_pkg::ST_IDLE;
                  end
               end
            end
            adc_seq_pkg::ST_WAIT: begin
               if (tick) begin
                  periods_r <= periods_r + 4'h1;
                  if (periods_r == adc_seq_pkg::ABORT_PERIODS - 4'h1) begin
                     state_r <= adc_seq_pkg::ST_IDLE;
                  end
               end
            end
            default: state_r <= adc_seq_pkg::ST_IDLE;
         endcase
      end
   end

   logic convDone;
   assign convDone = state_r == adc_seq_pkg::ST_CONV && ctrl1_r.goFlag && tick
      && periods_r == adc_seq_pkg::CONV_PERIODS - 4'h1;
   // Sample switch closed only while idle with the converter on
   assign sampleSwitch = state_r == adc_seq_pkg::ST_IDLE && ctrl1_r.converterOn;
   assign dacCode = sar_r;

   // Control register one
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl1_r <= '0;
      end else begin
         if (wrCtrl1) begin
            ctrl1_r <= {wb_dat_i[7:2], wb_dat_i[0]};
         end
         if (convDone) begin
            ctrl1_r.goFlag <= 1'b0;
         end
         if (trigStart) begin
            ctrl1_r.goFlag <= 1'b1;
         end
      end
   end

   // Control two and analog configuration
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl2_r <= '0;
         analogCfg_r <= {PINS{1'b1}};
      end else if (wrAccess) begin
         if (wb_adr_i == adc_seq_pkg::CTRL2_ADDR) begin
            ctrl2_r <= wb_dat_i[7:6];
         end
         if (wb_adr_i == adc_seq_pkg::ANCFG_ADDR) begin
            analogCfg_r <= wb_dat_i[PINS-1:0];
         end
      end
   end

   // Result pair, justified on load
   always_ff @(posedge core_clk) begin
      if (rst) begin
         resH_r <= 8'h00;
         resL_r <= 8'h00;
      end else if (convDone) begin
         if (ctrl2_r.resultJustify) begin
            resH_r <= {6'h00, sar_r[9:8]};
            resL_r <= sar_r[7:0];
         end else begin
            resH_r <= sar_r[9:2];
            resL_r <= {sar_r[1:0], 6'h00};
         end
      end else if (wrAccess) begin
         if (wb_adr_i == adc_seq_pkg::RESH_ADDR) begin
            resH_r <= wb_dat_i;
         end
         if (wb_adr_i == adc_seq_pkg::RESL_ADDR) begin
            resL_r <= wb_dat_i;
         end
      end
   end

   // Done flag: set wins over clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         conversionDoneFlag <= 1'b0;
      end else if (convDone) begin
         conversionDoneFlag <= 1'b1;
      end else if (wrAccess && wb_adr_i == adc_seq_pkg::STAT_ADDR) begin
         conversionDoneFlag <= wb_dat_i[0];
      end
   end

   // Bus answer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_r <= 1'b0;
         wb_dat_o <= 8'h00;
      end else begin
         ack_r <= busAccess;
         case (wb_adr_i)
            adc_seq_pkg::CTRL1_ADDR: wb_dat_o <= {ctrl1_r[6:1], 1'b0, ctrl1_r[0]};
            adc_seq_pkg::CTRL2_ADDR: wb_dat_o <= {ctrl2_r, 6'h00};
            adc_seq_pkg::RESH_ADDR: wb_dat_o <= resH_r;
            adc_seq_pkg::RESL_ADDR: wb_dat_o <= resL_r;
            adc_seq_pkg::PORT_ADDR: wb_dat_o <= 8'(pinLevel & ~analogCfg_r);
            adc_seq_pkg::ANCFG_ADDR: wb_dat_o <= 8'(analogCfg_r);
            adc_seq_pkg::STAT_ADDR: wb_dat_o <= {6'h00, conversionBusy, conversionDoneFlag};
            default: wb_dat_o <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== bench/adc_seq_monitor.sv ====
// Port assertions for the conversion sequencer.
// Assumes binding into every sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [2:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   input wire logic wb_sel_i,
   input wire logic wb_ack_o,
   input wire logic specialEventTrig,
   input wire logic timerClear,
   input wire logic conversionDoneFlag,
   input wire logic conversionBusy,
   input wire logic sampleSwitch,
   input wire logic [9:0] dacCode
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic ctl = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i
      && wb_adr_i == adc_seq_pkg::CTRL1_ADDR;
   AST_ACK: assert property (req |=> wb_ack_o)
      else $error("no ack after request");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   AST_TIMER: assert property (timerClear == specialEventTrig)
      else $error("timer clear not following trigger");
   AST_START: assert property (ctl && wb_dat_i[2] && wb_dat_i[0] && !conversionBusy
      |=> ##1 conversionBusy) else $error("go write did not start");
   AST_ABORT: assert property (ctl && !wb_dat_i[2] && conversionBusy
      |=> !$rose(conversionDoneFlag)) else $error("abort set done");
   AST_DONE: assert property ($rose(conversionDoneFlag) && !$past(wb_stb_i && wb_we_i)
      |-> $fell(conversionBusy)) else $error("done without end of conversion");
   AST_HOLD: assert property ($rose(conversionBusy) |-> !sampleSwitch)
      else $error("hold cap connected at start");
   AST_DAC: assert property (!conversionBusy ##1 !conversionBusy |-> $stable(dacCode))
      else $error("trial word moved while idle");
   AST_RESET: assert property (@(posedge core_clk) disable iff (1'b0) rst
      |=> !conversionBusy && !conversionDoneFlag && !wb_ack_o) else $error("reset not clean");
endmodule
bind adc_conversion_sequencer adc_seq_monitor u_mon (.core_clk, .rst, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .specialEventTrig, .timerClear,
   .conversionDoneFlag, .conversionBusy, .sampleSwitch, .dacCode);
`default_nettype wire

// ==== bench/sar_comparator_model.sv ====
// Comparator standing behind the hold capacitor.
// Assumes the bench sets the analog level.
`timescale 1ns/1ps
`default_nettype none
module sar_comparator_model (
   input wire logic [9:0] dacCode,
   input wire logic [9:0] analogLevel,
   output logic compGreater
);
   // Level at or above trial word keeps the bit
   assign compGreater = analogLevel >= dacCode;
endmodule
`default_nettype wire

// ==== bench/tb_adc_conversion_sequencer.sv ====
// Register level tests of the conversion sequencer.
// Assumes the comparator model and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer;
   logic core_clk, rcClk, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic wb_sel_i = 1'b1, specialEventTrig = 1'b0;
   logic [2:0] wb_adr_i = 3'h0, channelSelect;
   logic [7:0] wb_dat_i = 8'h00, pinLevel = 8'hff, wb_dat_o, q;
   logic [3:0] compare2ModeField = 4'h0;
   logic [9:0] level = 10'h000, dacCode, lv;
   logic wb_ack_o, compGreater, sampleSwitch, timerClear, conversionDoneFlag, conversionBusy;
   logic [2:0] codes [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
   int divs [7] = '{2, 4, 8, 16, 32, 64, 200};
   int bad_count = 0;
   int compares = 0;
   int n;
   adc_conversion_sequencer #(.PINS(8)) u_dut (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .rcClk, .compGreater, .pinLevel,
      .compare2ModeField, .specialEventTrig, .channelSelect, .sampleSwitch, .dacCode,
      .timerClear, .conversionDoneFlag, .conversionBusy);
   sar_comparator_model u_cmp (.dacCode, .analogLevel(level), .compGreater);
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      rcClk = 1'b0;
      #777;
      forever #2000 rcClk = ~rcClk;
   end
   task automatic chk(input string s, input logic [9:0] seen, input logic [9:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge core_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 40);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (k >= 40) begin
         bad_count++;
         end_sim();
      end
   endtask
   task automatic waitIdle;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while ((conversionBusy === 1'b1 || n < 2) && n < 3000);
      if (n >= 3000) begin
         bad_count++;
         end_sim();
      end
   endtask
   task automatic trig;
      @(posedge core_clk);
      specialEventTrig <= 1'b1;
      @(posedge core_clk);
      chk("timer clear", timerClear, 1);
      specialEventTrig <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      bus(0, adc_seq_pkg::ANCFG_ADDR, 0);
      chk("analog cfg", q, 8'hff);
      bus(0, adc_seq_pkg::PORT_ADDR, 0);
      chk("port", q, 8'h00);
      bus(1, adc_seq_pkg::ANCFG_ADDR, 8'h0f);
      bus(0, adc_seq_pkg::PORT_ADDR, 0);
      chk("port", q, 8'hf0);
      bus(0, 3'h7, 0);
      chk("unmapped", q, 8'h00);
      $display("test registers done");
      bus(1, adc_seq_pkg::CTRL1_ADDR, 8'h01);
      for (int i = 0; i < 7; i++) begin
         lv = 10'h3ff - 10'(i * 93);
         level <= lv;
         bus(1, adc_seq_pkg::CTRL2_ADDR, {i[0], codes[i][2], 6'h00});
         bus(1, adc_seq_pkg::CTRL1_ADDR, {codes[i][1:0], 3'(i), 3'b101});
         waitIdle();
         chk("period", 10'(n > 11 * divs[i] - 4 && n <= 12 * divs[i] + 4), 1);
         chk("done", conversionDoneFlag, 1);
         bus(0, adc_seq_pkg::CTRL1_ADDR, 0);
         chk("go", q[2], 0);
         bus(0, adc_seq_pkg::RESH_ADDR, 0);
         chk("high", q, i[0] ? {6'h00, lv[9:8]} : lv[9:2]);
         bus(0, adc_seq_pkg::RESL_ADDR, 0);
         chk("low", q, i[0] ? lv[7:0] : {lv[1:0], 6'h00});
         bus(1, adc_seq_pkg::STAT_ADDR, 0);
      end
      $display("test clock selects done");
      bus(1, adc_seq_pkg::CTRL2_ADDR, 0);
      bus(1, adc_seq_pkg::CTRL1_ADDR, 8'h85);
      level <= 10'h000;
      repeat (100) @(posedge core_clk);
      bus(1, adc_seq_pkg::CTRL1_ADDR, 8'h81);
      waitIdle();
      chk("abort wait", 10'(n >= 30 && n <= 70), 1);
      chk("abort done", conversionDoneFlag, 0);
      chk("acquire", sampleSwitch, 1);
      bus(0, adc_seq_pkg::RESH_ADDR, 0);
      chk("kept", q, lv[9:2]);
      $display("test abort done");
      compare2ModeField <= 4'h3;
      bus(1, adc_seq_pkg::CTRL1_ADDR, 8'h01);
      trig();
      chk("other mode", conversionBusy, 0);
      compare2ModeField <= adc_seq_pkg::TRIG_MODE_SPECIAL;
      repeat (50) @(posedge core_clk);
      trig();
      chk("trigger", conversionBusy, 1);
      waitIdle();
      bus(1, adc_seq_pkg::CTRL1_ADDR, 8'h00);
      trig();
      chk("off", conversionBusy, 0);
      $display("test trigger done");
      bus(1, adc_seq_pkg::CTRL1_ADDR, 8'h01);
      bus(1, adc_seq_pkg::CTRL1_ADDR, 8'h05);
      repeat (5) @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk("busy", conversionBusy, 0);
      bus(0, adc_seq_pkg::CTRL1_ADDR, 0);
      chk("ctrl", q, 8'h00);
      $display("test reset done");
      end_sim();
   end
endmodule
`default_nettype wire
